// file: logic/sss_map.svh
// register map, field positions, reset values and counts of the serial block
`ifndef SSS_MAP_SVH
`define SSS_MAP_SVH

`define SSS_RCTL_OFS 8'h00
`define SSS_TCTL_OFS 8'h04
`define SSS_PFR_OFS 8'h08
`define SSS_RXD_OFS 8'h0C
`define SSS_TXD_OFS 8'h10
`define SSS_PIE_OFS 8'h14
`define SSS_ICTL_OFS 8'h18
`define SSS_EVT_OFS 8'h1C
`define SSS_EVCLR_OFS 8'h20
`define SSS_EVEN_OFS 8'h24

`define SSS_PFR_RECEIVE_COMPLETE_FLAG 0
`define SSS_PFR_TRANSMIT_BUFFER_EMPTY_FLAG 1
`define SSS_PFR_OERR 2
`define SSS_PFR_BUSY 3
`define SSS_PFR_ARMED 4
`define SSS_PFR_ASLEEP 5

`define SSS_RCTL_RST 2'h0
`define SSS_TCTL_RST 3'h0
`define SSS_PIE_RST 2'h0
`define SSS_ICTL_RST 2'h0
`define SSS_EVEN_RST 3'h0

`define SSS_WORD_BITS 8
`define SSS_ISR_VECTOR 12'h004

`endif

// file: logic/sss_pkg.sv
// types shared by the synchronous-slave serial block
`default_nettype none
package sss_pkg;
	typedef struct packed {
		logic rx_en;
		logic port_en;
	} sss_rctl_t;
	typedef struct packed {
		logic tx_en;
		logic slave;
		logic sync;
	} sss_tctl_t;
	typedef struct packed {
		logic transmit_irq_enable;
		logic receive_irq_enable;
	} sss_pie_t;
	typedef struct packed {
		logic peripheral_irq_gate;
		logic global_irq_enable;
	} sss_ictl_t;
	typedef struct packed {
		logic ovr;
		logic tx;
		logic rx;
	} sss_evt_t;
	typedef enum logic [1:0] {SSS_OFF, SSS_RX, SSS_TX} sss_mode_t;
endpackage
`default_nettype wire

// file: logic/sss_sync.sv
// two-stage pin synchroniser with edge detection on the settled level
`timescale 1ns/10ps
`default_nettype none
module sss_sync #(
	parameter int W = 2
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [W-1:0] async_in,
	output logic [W-1:0] sync_out,
	output logic [W-1:0] rise,
	output logic [W-1:0] fall
);
	logic [W-1:0] meta_q;
	logic [W-1:0] sync_q;
	logic [W-1:0] prev_q;

	// first stage feeds only the second stage
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			meta_q <= '0;
			sync_q <= '0;
			prev_q <= '0;
		end else begin
			meta_q <= async_in;
			sync_q <= meta_q;
			prev_q <= sync_q;
		end
	end

	// edges of the settled level
	assign sync_out = sync_q;
	assign rise = sync_q & ~prev_q;
	assign fall = ~sync_q & prev_q;
endmodule
`default_nettype wire

// file: logic/sss_top.sv
// synchronous-slave serial engine with AXI4-Lite registers and sleep wake
`timescale 1ns/10ps
`default_nettype none
`include "sss_map.svh"
module sss_top import sss_pkg::*; #(
	parameter int ADDR_W = 8,
	parameter int WORD_BITS = `SSS_WORD_BITS
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [ADDR_W-1:0] awaddr,
	input wire logic [2:0] awprot,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [ADDR_W-1:0] araddr,
	input wire logic [2:0] arprot,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	input wire logic sleep,
	input wire logic shift_clock_pin,
	input wire logic serial_data_pin_in,
	output logic serial_data_pin_out,
	output logic serial_data_pin_oe,
	output logic irq,
	output logic wake,
	output logic isr_call,
	output logic [11:0] isr_vector
);
	localparam int CNT_W = $clog2(WORD_BITS);
	localparam logic [CNT_W-1:0] LAST = CNT_W'(WORD_BITS - 1);

	if (WORD_BITS < 2 || WORD_BITS > 16) begin : g_bad_word
		$error("WORD_BITS must lie in 2..16");
	end
	if (ADDR_W < 8 || ADDR_W > 32) begin : g_bad_addr
		$error("ADDR_W must lie in 8..32");
	end

	// word-aligned address match
	function automatic logic sss_hit(input logic [ADDR_W-1:0] a, input logic [7:0] ofs);
		return {a[ADDR_W-1:2], 2'b00} == ADDR_W'(ofs);
	endfunction

	function automatic logic sss_mapped(input logic [ADDR_W-1:0] a);
		return sss_hit(a, `SSS_RCTL_OFS) || sss_hit(a, `SSS_TCTL_OFS) ||
			sss_hit(a, `SSS_PFR_OFS) || sss_hit(a, `SSS_RXD_OFS) ||
			sss_hit(a, `SSS_TXD_OFS) || sss_hit(a, `SSS_PIE_OFS) ||
			sss_hit(a, `SSS_ICTL_OFS) || sss_hit(a, `SSS_EVT_OFS) ||
			sss_hit(a, `SSS_EVCLR_OFS) || sss_hit(a, `SSS_EVEN_OFS);
	endfunction

	sss_rctl_t rctl_q;
	sss_tctl_t tctl_q;
	sss_pie_t pie_q;
	sss_ictl_t ictl_q;
	sss_evt_t evt_q;
	sss_evt_t even_q;
	sss_evt_t evt_set;
	sss_mode_t mode;
	logic [1:0] pin_s;
	logic [1:0] pin_fall;
	logic clk_fall;
	logic aw_held_q;
	logic w_held_q;
	logic [ADDR_W-1:0] aw_addr_q;
	logic [31:0] w_data_q;
	logic [3:0] w_strb_q;
	logic wr_go;
	logic wr_b0;
	logic rd_go;
	logic [31:0] rd_mux;
	logic sleep_q;
	logic armed_q;
	logic sync_slave;
	logic link_run;
	logic [CNT_W-1:0] bit_cnt_q;
	logic [WORD_BITS-1:0] rx_sh_q;
	logic [WORD_BITS-1:0] rx_buf_q;
	logic receive_complete_flag_q;
	logic oerr_q;
	logic rxd_rd;
	logic rx_word_done;
	logic rx_load;
	logic overrun;
	logic [WORD_BITS-1:0] tx_buf_q;
	logic buf_full_q;
	logic [WORD_BITS-1:0] tsr_q;
	logic tsr_valid_q;
	logic transmit_buffer_empty_flag;
	logic txd_wr;
	logic tx_shift;
	logic tx_word_done;
	logic tsr_load;
	logic rx_req;
	logic rx_irq;
	logic tx_irq;
	logic wake_d;

	// both pins come from the master's domain
	sss_sync #(.W(2)) u_sync (
		.aclk(aclk),
		.aresetn(aresetn),
		.async_in({shift_clock_pin, serial_data_pin_in}),
		.sync_out(pin_s),
		.rise(),
		.fall(pin_fall)
	);
	assign clk_fall = pin_fall[1];

	// bus handshakes
	assign awready = !aw_held_q && !bvalid;
	assign wready = !w_held_q && !bvalid;
	assign arready = !rvalid;
	assign wr_go = aw_held_q && w_held_q && !bvalid;
	assign wr_b0 = wr_go && w_strb_q[0];
	assign rd_go = arvalid && arready;

	// address and data may arrive in either order
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_q <= 1'b0;
			w_held_q <= 1'b0;
			aw_addr_q <= '0;
			w_data_q <= 32'h0000_0000;
			w_strb_q <= 4'h0;
		end else begin
			if (awvalid && awready) begin
				aw_held_q <= 1'b1;
				aw_addr_q <= awaddr;
			end else if (wr_go) begin
				aw_held_q <= 1'b0;
			end
			if (wvalid && wready) begin
				w_held_q <= 1'b1;
				w_data_q <= wdata;
				w_strb_q <= wstrb;
			end else if (wr_go) begin
				w_held_q <= 1'b0;
			end
		end
	end

	// write response, error on unmapped address
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid <= 1'b0;
			bresp <= 2'h0;
		end else if (wr_go) begin
			bvalid <= 1'b1;
			bresp <= sss_mapped(aw_addr_q) ? 2'h0 : 2'h2;
		end else if (bready) begin
			bvalid <= 1'b0;
		end
	end

	// software-written configuration
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rctl_q <= `SSS_RCTL_RST;
			tctl_q <= `SSS_TCTL_RST;
			pie_q <= `SSS_PIE_RST;
			ictl_q <= `SSS_ICTL_RST;
			even_q <= `SSS_EVEN_RST;
		end else if (wr_b0) begin
			if (sss_hit(aw_addr_q, `SSS_RCTL_OFS)) rctl_q <= w_data_q[1:0];
			if (sss_hit(aw_addr_q, `SSS_TCTL_OFS)) tctl_q <= w_data_q[2:0];
			if (sss_hit(aw_addr_q, `SSS_PIE_OFS)) pie_q <= w_data_q[1:0];
			if (sss_hit(aw_addr_q, `SSS_ICTL_OFS)) ictl_q <= w_data_q[1:0];
			if (sss_hit(aw_addr_q, `SSS_EVEN_OFS)) even_q <= w_data_q[2:0];
		end
	end

	// read data mux
	always_comb begin
		rd_mux = 32'h0000_0000;
		if (sss_hit(araddr, `SSS_RCTL_OFS)) rd_mux[1:0] = rctl_q;
		if (sss_hit(araddr, `SSS_TCTL_OFS)) rd_mux[2:0] = tctl_q;
		if (sss_hit(araddr, `SSS_PFR_OFS)) begin
			rd_mux[`SSS_PFR_RECEIVE_COMPLETE_FLAG] = receive_complete_flag_q;
			rd_mux[`SSS_PFR_TRANSMIT_BUFFER_EMPTY_FLAG] = transmit_buffer_empty_flag;
			rd_mux[`SSS_PFR_OERR] = oerr_q;
			rd_mux[`SSS_PFR_BUSY] = tsr_valid_q;
			rd_mux[`SSS_PFR_ARMED] = armed_q;
			rd_mux[`SSS_PFR_ASLEEP] = sleep_q;
		end
		if (sss_hit(araddr, `SSS_RXD_OFS)) rd_mux[WORD_BITS-1:0] = rx_buf_q;
		if (sss_hit(araddr, `SSS_PIE_OFS)) rd_mux[1:0] = pie_q;
		if (sss_hit(araddr, `SSS_ICTL_OFS)) rd_mux[1:0] = ictl_q;
		if (sss_hit(araddr, `SSS_EVT_OFS)) rd_mux[2:0] = evt_q;
		if (sss_hit(araddr, `SSS_EVEN_OFS)) rd_mux[2:0] = even_q;
	end

	// read channel, data registered one cycle after the address
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid <= 1'b0;
			rdata <= 32'h0000_0000;
			rresp <= 2'h0;
		end else if (rd_go) begin
			rvalid <= 1'b1;
			rdata <= rd_mux;
			rresp <= sss_mapped(araddr) ? 2'h0 : 2'h2;
		end else if (rready) begin
			rvalid <= 1'b0;
		end
	end

	// sync-slave arming is latched into armed_q when sleep begins
	assign sync_slave = rctl_q.port_en && tctl_q.sync && tctl_q.slave;
	assign link_run = sync_slave && (!sleep || armed_q);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sleep_q <= 1'b0;
			armed_q <= 1'b0;
		end else begin
			sleep_q <= sleep;
			if (sleep && !sleep_q) begin
				armed_q <= sync_slave;
			end else if (!sleep) begin
				armed_q <= 1'b1;
			end
		end
	end

	// receive has the pin when both directions are enabled
	always_comb begin
		mode = SSS_OFF;
		if (link_run && rctl_q.rx_en) begin
			mode = SSS_RX;
		end else if (link_run && tctl_q.tx_en) begin
			mode = SSS_TX;
		end
	end

	// bit counter, one bit per external falling edge
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bit_cnt_q <= '0;
		end else begin
			unique case (mode)
				SSS_OFF: bit_cnt_q <= '0;
				SSS_RX: begin
					if (clk_fall) bit_cnt_q <= (bit_cnt_q == LAST) ? '0 : bit_cnt_q + 1'b1;
				end
				SSS_TX: begin
					if (!tsr_valid_q) begin
						bit_cnt_q <= '0;
					end else if (clk_fall) begin
						bit_cnt_q <= (bit_cnt_q == LAST) ? '0 : bit_cnt_q + 1'b1;
					end
				end
			endcase
		end
	end

	// receive path
	assign rxd_rd = rd_go && sss_hit(araddr, `SSS_RXD_OFS);
	assign rx_word_done = (mode == SSS_RX) && clk_fall && (bit_cnt_q == LAST);
	assign rx_load = rx_word_done && (!receive_complete_flag_q || rxd_rd);
	assign overrun = rx_word_done && receive_complete_flag_q && !rxd_rd;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rx_sh_q <= '0;
			rx_buf_q <= '0;
		end else begin
			if ((mode == SSS_RX) && clk_fall) begin
				rx_sh_q <= {pin_s[0], rx_sh_q[WORD_BITS-1:1]};
			end
			if (rx_load) begin
				rx_buf_q <= {pin_s[0], rx_sh_q[WORD_BITS-1:1]};
			end
		end
	end

	// receive-complete flag: a new word wins over the unloading read
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			receive_complete_flag_q <= 1'b0;
			oerr_q <= 1'b0;
		end else begin
			if (rx_load) begin
				receive_complete_flag_q <= 1'b1;
			end else if (rxd_rd) begin
				receive_complete_flag_q <= 1'b0;
			end
			if (overrun) begin
				oerr_q <= 1'b1;
			end else if (!rctl_q.rx_en) begin
				oerr_q <= 1'b0;
			end
		end
	end

	// transmit path
	assign transmit_buffer_empty_flag = !buf_full_q;
	assign txd_wr = wr_b0 && sss_hit(aw_addr_q, `SSS_TXD_OFS) && !buf_full_q;
	assign tx_shift = (mode == SSS_TX) && tsr_valid_q && clk_fall;
	assign tx_word_done = tx_shift && (bit_cnt_q == LAST);
	assign tsr_load = buf_full_q && (!tsr_valid_q || tx_word_done);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tx_buf_q <= '0;
			buf_full_q <= 1'b0;
		end else if (txd_wr) begin
			tx_buf_q <= w_data_q[WORD_BITS-1:0];
			buf_full_q <= 1'b1;
		end else if (tsr_load) begin
			buf_full_q <= 1'b0;
		end
	end

	// shifter, least significant bit first
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tsr_q <= '0;
			tsr_valid_q <= 1'b0;
		end else if (tsr_load) begin
			tsr_q <= tx_buf_q;
			tsr_valid_q <= 1'b1;
		end else if (tx_word_done) begin
			tsr_valid_q <= 1'b0;
		end else if (tx_shift) begin
			tsr_q <= {1'b0, tsr_q[WORD_BITS-1:1]};
		end
	end

	// data pin drive
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			serial_data_pin_oe <= 1'b0;
		end else begin
			serial_data_pin_oe <= (mode == SSS_TX) && tsr_valid_q;
		end
	end
	assign serial_data_pin_out = tsr_q[0];

	// sticky events, set wins over clear
	assign evt_set = '{ovr: overrun, tx: tx_word_done, rx: rx_load};

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			evt_q <= '0;
		end else if (wr_b0 && sss_hit(aw_addr_q, `SSS_EVCLR_OFS)) begin
			evt_q <= (evt_q & ~sss_evt_t'(w_data_q[2:0])) | evt_set;
		end else begin
			evt_q <= evt_q | evt_set;
		end
	end

	// interrupt gating and wake
	assign rx_req = receive_complete_flag_q && pie_q.receive_irq_enable && ictl_q.peripheral_irq_gate;
	assign rx_irq = rx_req && ictl_q.global_irq_enable;
	assign tx_irq = transmit_buffer_empty_flag && pie_q.transmit_irq_enable && ictl_q.peripheral_irq_gate;
	assign wake_d = sleep && (rx_req || tx_irq);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq <= 1'b0;
			wake <= 1'b0;
			isr_call <= 1'b0;
			isr_vector <= `SSS_ISR_VECTOR;
		end else begin
			irq <= rx_irq || tx_irq || (|(evt_q & even_q));
			wake <= wake_d;
			isr_call <= wake_d && !wake && ictl_q.global_irq_enable;
			isr_vector <= `SSS_ISR_VECTOR;
		end
	end

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	rx_flag_set_a: assert property (rx_load |=> receive_complete_flag_q && rx_buf_q == $past({pin_s[0], rx_sh_q[WORD_BITS-1:1]}))
		else $error("received word not flagged");
	rx_read_clr_a: assert property (rxd_rd && !rx_word_done |=> !receive_complete_flag_q)
		else $error("receive read left flag set");
	rx_gate_a: assert property (receive_complete_flag_q && !(pie_q.receive_irq_enable && ictl_q.peripheral_irq_gate &&
		ictl_q.global_irq_enable) && !tx_irq && !(|(evt_q & even_q)) |=> !irq)
		else $error("receive interrupt without enables");
	tx_gate_a: assert property (transmit_buffer_empty_flag && pie_q.transmit_irq_enable && ictl_q.peripheral_irq_gate |=> irq)
		else $error("transmit interrupt missing");
	tx_write_clr_a: assert property (txd_wr |=> !transmit_buffer_empty_flag ##1 (transmit_buffer_empty_flag || !tsr_valid_q || tx_word_done || $stable(tsr_q)))
		else $error("transmit write did not clear flag");
	tx_reload_a: assert property (tx_word_done && buf_full_q |=> tsr_valid_q && transmit_buffer_empty_flag && tsr_q == $past(tx_buf_q))
		else $error("shifter not reloaded");
	tx_refill_a: assert property (tsr_load ##1 txd_wr |=> buf_full_q && !transmit_buffer_empty_flag)
		else $error("new character not accepted");
	word_len_a: assert property (rx_load |-> bit_cnt_q == LAST ##1 bit_cnt_q == 0)
		else $error("word length wrong");
	halt_a: assert property (!link_run |=> bit_cnt_q == 0 && !serial_data_pin_oe)
		else $error("shifting while not permitted");
	arm_a: assert property ($rose(sleep) |=> armed_q == $past(sync_slave))
		else $error("sleep arming wrong");
	rx_pin_a: assert property ((mode == SSS_RX) && clk_fall |=> rx_sh_q[WORD_BITS-1] == $past(pin_s[0]))
		else $error("receive bit not taken");
	drive_a: assert property (serial_data_pin_oe |-> $past(mode == SSS_TX && tsr_valid_q))
		else $error("data pin driven outside transmit");
	isr_a: assert property (isr_call |-> wake && $past(ictl_q.global_irq_enable) ##1 !isr_call)
		else $error("vector call without wake");

	rx_sleep_c: cover property (sleep && rx_load);
	tx_chain_c: cover property (tx_word_done && buf_full_q);
	isr_c: cover property (isr_call);
	ovr_c: cover property (overrun);
endmodule
`default_nettype wire

// file: verif/sss_master_model.sv
// behavioural synchronous master that supplies the shift clock and data
`timescale 1ns/10ps
`default_nettype none
module sss_master_model #(
	parameter int HALF_NS = 160
) (
	input wire logic dev_out,
	input wire logic dev_oe,
	output logic shift_clk,
	output logic data_line
);
	logic m_bit;
	logic m_en;
	// resolved data wire: device, master, or the inverse of the last bit once released
	assign data_line = dev_oe ? dev_out : (m_en ? m_bit : ~m_bit);
	// clock idles high and stands still outside frames
	initial begin
		shift_clk = 1'b1;
		m_bit = 1'b0;
		m_en = 1'b0;
	end
	// one word lsb first: data changes after the rise, is held across the fall
	task automatic xfer(input logic [7:0] tx, input logic drv, output logic [7:0] rx);
		for (int i = 0; i < 8; i++) begin
			m_bit = tx[i];
			m_en = drv;
			#HALF_NS shift_clk = 1'b0;
			rx[i] = data_line;
			#HALF_NS shift_clk = 1'b1;
		end
		m_en = 1'b0;
	endtask
endmodule
`default_nettype wire

// file: verif/sync_slave_serial_sleep_tb.sv
// self-checking bench for the synchronous-slave serial block
`timescale 1ns/10ps
`default_nettype none
`include "sss_map.svh"
module sync_slave_serial_sleep_tb;
	import sss_pkg::*;
	logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready, sleep, sck, sdat, dout, doe;
	logic irq, wake, isr_call;
	logic [7:0] awaddr, araddr, rx;
	logic [31:0] wdata, rdata, rd;
	logic [1:0] bresp, rresp;
	logic [11:0] isr_vector;
	int error_cnt, checks, isr_n;
	sss_top i_dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(3'h0),
		.awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid),
		.wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
		.arprot(3'h0), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
		.rvalid(rvalid), .rready(rready), .sleep(sleep), .shift_clock_pin(sck),
		.serial_data_pin_in(sdat), .serial_data_pin_out(dout), .serial_data_pin_oe(doe),
		.irq(irq), .wake(wake), .isr_call(isr_call), .isr_vector(isr_vector));
	sss_master_model i_mst (.dev_out(dout), .dev_oe(doe), .shift_clk(sck), .data_line(sdat));
	// 25 MHz clock
	always #20 aclk = ~aclk;
	// count service-routine calls
	always @(posedge aclk) begin
		if (isr_call === 1'b1) isr_n++;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// axi4-lite write, response code compared
	task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		logic aw_d, w_d;
		aw_d = 1'b0;
		w_d = 1'b0;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (awvalid && awready) begin
				aw_d = 1'b1;
				awvalid <= 1'b0;
			end
			if (wvalid && wready) begin
				w_d = 1'b1;
				wvalid <= 1'b0;
			end
		end while (!(aw_d && w_d));
		do @(posedge aclk); while (bvalid !== 1'b1);
		bready <= 1'b0;
		chk({30'h0, bresp}, {30'h0, er});
	endtask
	// axi4-lite read
	task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge aclk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge aclk); while (rvalid !== 1'b1);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [31:0] mask, input logic [31:0] exp);
		logic [31:0] d;
		logic [1:0] r;
		axr(a, d, r);
		chk(d & mask, exp);
	endtask
	task automatic wait_wake();
		for (int i = 0; i < 60 && wake !== 1'b1; i++) @(posedge aclk);
		repeat (2) @(posedge aclk);
	endtask
	task automatic results();
		$display("checks=%0d errors=%0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	// watchdog
	initial begin
		#2000000;
		error_cnt++;
		results();
	end
	initial begin
		logic [1:0] r;
		aclk = 1'b0;
		aresetn = 1'b0;
		{awvalid, wvalid, bready, arvalid, rready, sleep} = 6'h00;
		awaddr = 8'h00;
		araddr = 8'h00;
		wdata = 32'h0;
		error_cnt = 0;
		checks = 0;
		isr_n = 0;
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (4) @(posedge aclk);
		// reset state and an unmapped address
		rdchk(`SSS_PFR_OFS, 32'h3, 32'h2);
		rdchk(`SSS_RCTL_OFS, 32'hFFFFFFFF, 32'h0);
		axr(8'h30, rd, r);
		chk({30'h0, r}, 32'h2);
		axw(8'h30, 32'h1, 2'h2);
		$display("reset checks done");
		// synchronous master (non-slave) config: no shifting in sleep
		axw(`SSS_RCTL_OFS, 32'h3, 2'h0);
		axw(`SSS_TCTL_OFS, 32'h1, 2'h0);
		sleep <= 1'b1;
		i_mst.xfer(8'hFF, 1'b1, rx);
		repeat (10) @(posedge aclk);
		rdchk(`SSS_PFR_OFS, 32'h1, 32'h0);
		sleep <= 1'b0;
		$display("non-slave sleep done");
		// slave receive in sleep with all three enables
		axw(`SSS_TCTL_OFS, 32'h3, 2'h0);
		axw(`SSS_PIE_OFS, 32'h1, 2'h0);
		axw(`SSS_ICTL_OFS, 32'h3, 2'h0);
		sleep <= 1'b1;
		i_mst.xfer(8'hA5, 1'b1, rx);
		wait_wake();
		chk({31'h0, wake}, 32'h1);
		chk({31'h0, irq}, 32'h1);
		chk(isr_n, 32'h1);
		chk({20'h0, isr_vector}, 32'h004);
		rdchk(`SSS_RXD_OFS, 32'hFF, 32'hA5);
		rdchk(`SSS_PFR_OFS, 32'h1, 32'h0);
		repeat (2) @(posedge aclk);
		chk({31'h0, wake}, 32'h0);
		sleep <= 1'b0;
		$display("receive in sleep done");
		// global enable off: wake but no receive interrupt, event path then
		axw(`SSS_EVCLR_OFS, 32'h7, 2'h0);
		axw(`SSS_ICTL_OFS, 32'h2, 2'h0);
		sleep <= 1'b1;
		i_mst.xfer(8'h5A, 1'b1, rx);
		wait_wake();
		chk({31'h0, irq}, 32'h0);
		chk(isr_n, 32'h1);
		rdchk(`SSS_EVT_OFS, 32'h7, 32'h1);
		axw(`SSS_EVEN_OFS, 32'h1, 2'h0);
		repeat (2) @(posedge aclk);
		chk({31'h0, irq}, 32'h1);
		axw(`SSS_EVCLR_OFS, 32'h1, 2'h0);
		rdchk(`SSS_EVT_OFS, 32'h7, 32'h0);
		chk({31'h0, irq}, 32'h0);
		rdchk(`SSS_RXD_OFS, 32'hFF, 32'h5A);
		sleep <= 1'b0;
		$display("gated receive done");
		// slave transmit in sleep, back-to-back words with reload
		axw(`SSS_RCTL_OFS, 32'h1, 2'h0);
		axw(`SSS_TCTL_OFS, 32'h7, 2'h0);
		axw(`SSS_PIE_OFS, 32'h2, 2'h0);
		axw(`SSS_TXD_OFS, 32'h3C, 2'h0);
		axw(`SSS_TXD_OFS, 32'h96, 2'h0);
		rdchk(`SSS_PFR_OFS, 32'h2, 32'h0);
		sleep <= 1'b1;
		repeat (4) @(posedge aclk);
		chk({31'h0, doe}, 32'h1);
		i_mst.xfer(8'h00, 1'b0, rx);
		chk({24'h0, rx}, 32'h3C);
		wait_wake();
		chk({31'h0, wake}, 32'h1);
		chk({31'h0, irq}, 32'h1);
		chk(isr_n, 32'h1);
		rdchk(`SSS_PFR_OFS, 32'h2, 32'h2);
		axw(`SSS_TXD_OFS, 32'hC3, 2'h0);
		rdchk(`SSS_PFR_OFS, 32'h2, 32'h0);
		i_mst.xfer(8'h00, 1'b0, rx);
		chk({24'h0, rx}, 32'h96);
		i_mst.xfer(8'h00, 1'b0, rx);
		chk({24'h0, rx}, 32'hC3);
		sleep <= 1'b0;
		$display("transmit in sleep done");
		results();
	end
endmodule
`default_nettype wire
